// [rtl/mpo_map.vh]
/*
 * register map, field positions, reset values and timing counts of the
 * meter pulse and monitor output block.
 * assumes: included by the block's design file and by the test files.
 */
`ifndef MPO_MAP_VH
`define MPO_MAP_VH

`define MPO_A_CTRL 12'h000
`define MPO_A_MON_ADDR 12'h004
`define MPO_A_PULSE 12'h008
`define MPO_A_STATUS 12'h00c
`define MPO_A_CLEAR 12'h010
`define MPO_A_ENABLE 12'h014
`define MPO_A_MON_DATA 12'h018
`define MPO_A_FIFO 12'h01c

`define MPO_C_MON_EN 0
`define MPO_C_INV 1
`define MPO_C_PASS 2
`define MPO_C_EQU_LO 4
`define MPO_C_EQU_HI 6
`define MPO_C_EXPORT_X 8
`define MPO_C_EXPORT_Y 9

`define MPO_ST_W 0
`define MPO_ST_V 1
`define MPO_ST_X 2
`define MPO_ST_Y 3
`define MPO_ST_PASS 4
`define MPO_ST_WIDTH 5

`define MPO_ZERO32 32'h0000_0000
`define MPO_ZERO8 8'h00
`define MPO_ZERO5 5'h00
`define MPO_FIFO_FULL 4'h8
`define MPO_PAIR 4'h2
`define MPO_SEQ3 3'h3
`define MPO_SEQ4 3'h4
`define MPO_EQU_TWO 3'h2

`define MPO_WORD_CYC_NS 203
`define MPO_WORD_LEN 35
`define MPO_FLAG_LEN 3
`define MPO_FRAME_SLOW 13
`define MPO_FIFO_DEPTH 8
`define MPO_SLOW_HZ 32768
`define MPO_CLK_HZ 10000000

`endif

// [rtl/mpo_top.v]
/*
 * meter pulse and monitor output block: four pulse generators with shared
 * polarity, aux pulses to segment io six/seven, energy pulse sign fifo
 * spread over the mux frame, real-time monitor serialiser, equation select.
 * assumes: single ahb-lite master, hclk 10 mhz, engine pass strobe written
 * by firmware or the engine through the control register.
 */
// How it works
// - monitor samples four selected ram words
// - words shift out at a pass start seen while idle
// - monitor runs only while enable set
// - word is 35 bits, flag first
// - serial bits shift on test bit clock
// - four pulse outputs, each may interrupt
// - one invert bit sets polarity of all
// - status flags exported via pulse generators
// - aux x on io six, y on seven
// - aux pulses change at most once per pass
// - real pulse is active, reactive is reactive
// - sign bits captured into 8-bit fifo
// - fifo bits released one pair per frame, at slot 0
// - three-bit equation select field
// - equation picks mux sequence length
// - frame lasts 13 slow clock cycles
`include "mpo_map.vh"
`timescale 1ns/1ps
`default_nettype none

module mpo_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg [9:0] ram_addr,
    input wire [31:0] ram_rdata,
    input wire engine_clock,
    input wire test_bit_clock,
    input wire slow_clock_32k,
    output reg test_mux_output_pin,
    output reg real_energy_pulse,
    output reg reactive_energy_pulse,
    output reg segment_io_six,
    output reg segment_io_seven,
    output reg [2:0] mux_sequence_len,
    output reg irq
);
    // slow_clock_32k is an enable strobe sampled on hclk; engine_clock is unused
    localparam WORD_NS = `MPO_WORD_LEN * `MPO_WORD_CYC_NS;
    localparam SPREAD = `MPO_FRAME_SLOW;

    localparam ST_IDLE = 3'b001;
    localparam ST_LOAD = 3'b010;
    localparam ST_SHIFT = 3'b100;

    reg [31:0] ctrl_r;
    reg [31:0] mon_addr_r;
    reg [3:0] pulse_r;
    reg [`MPO_ST_WIDTH-1:0] status_r;
    reg [`MPO_ST_WIDTH-1:0] enable_r;
    reg [31:0] mon_data_r;
    reg [7:0] fifo_r;
    reg [3:0] fifo_cnt_r;
    reg [3:0] slot_r;
    reg [1:0] word_r;
    reg [5:0] bit_r;
    reg [34:0] shreg_r;
    reg [2:0] state_r;
    reg x_r;
    reg y_r;
    reg w_r;
    reg v_r;
    reg ap_sel_r;
    reg ap_write_r;
    reg [11:0] ap_addr_r;
    reg [4:0] ev_nxt;
    reg [4:0] clr_nxt;
    reg pass_nxt;
    reg [7:0] fifo_nxt;
    reg [3:0] fifo_cnt_nxt;
    reg release_nxt;
    reg [9:0] mon_next_addr_nxt;
    reg [2:0] seq_len_nxt;
    reg [`MPO_ST_WIDTH-1:0] status_nxt;
    reg [31:0] rd_nxt;
    wire [3:0] pin_nxt;

    wire ap_go = hsel & hready & htrans[1];
    wire wr_now = ap_sel_r & ap_write_r;
    wire inv = ctrl_r[`MPO_C_INV];
    wire mon_en = ctrl_r[`MPO_C_MON_EN];
    wire [2:0] meter_equation_select = ctrl_r[`MPO_C_EQU_HI:`MPO_C_EQU_LO];
    // active-high pulse levels before the common polarity stage
    wire [3:0] act = {y_r, x_r, v_r, w_r};
    // last bit of a word, and last word of a monitor round
    wire word_last = bit_r == `MPO_WORD_LEN - 1;
    wire round_last = word_r == 2'd3;
    genvar g;

    // ahb-lite slave: zero wait states, always okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_sel_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ap_sel_r <= ap_go;
            ap_write_r <= hwrite;
            ap_addr_r <= haddr[11:0];
        end
    end

    // read mux; unmapped and write-only offsets read as zero
    always @* begin
        case (haddr[11:0])
            `MPO_A_CTRL: rd_nxt = ctrl_r;
            `MPO_A_MON_ADDR: rd_nxt = mon_addr_r;
            `MPO_A_PULSE: rd_nxt = {28'h000_0000, pulse_r};
            `MPO_A_STATUS: rd_nxt = {27'h000_0000, status_r};
            `MPO_A_ENABLE: rd_nxt = {27'h000_0000, enable_r};
            `MPO_A_MON_DATA: rd_nxt = mon_data_r;
            `MPO_A_FIFO: rd_nxt = {20'h0_0000, fifo_cnt_r, fifo_r};
            default: rd_nxt = `MPO_ZERO32;
        endcase
    end

    // read data is taken in the address phase, so it stands in the data
    // phase with no wait state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `MPO_ZERO32;
        end else if (ap_go && !hwrite) begin
            hrdata <= rd_nxt;
        end
    end

    // control; pass bit self-clears and marks an engine pass start
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `MPO_ZERO32;
            mon_addr_r <= `MPO_ZERO32;
            pulse_r <= 4'h0;
            enable_r <= `MPO_ZERO5;
        end else begin
            ctrl_r[`MPO_C_PASS] <= 1'b0;
            if (wr_now) begin
                case (ap_addr_r)
                    `MPO_A_CTRL: ctrl_r <= hwdata;
                    `MPO_A_MON_ADDR: mon_addr_r <= hwdata;
                    `MPO_A_PULSE: pulse_r <= hwdata[3:0];
                    `MPO_A_ENABLE: enable_r <= hwdata[`MPO_ST_WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    always @* begin
        pass_nxt = ctrl_r[`MPO_C_PASS];
        clr_nxt = (wr_now && ap_addr_r == `MPO_A_CLEAR) ?
            hwdata[`MPO_ST_WIDTH-1:0] : `MPO_ZERO5;
    end

    // events: a pulse source is active, or an engine pass starts
    always @* begin
        ev_nxt = `MPO_ZERO5;
        ev_nxt[`MPO_ST_W] = w_r;
        ev_nxt[`MPO_ST_V] = v_r;
        ev_nxt[`MPO_ST_X] = x_r;
        ev_nxt[`MPO_ST_Y] = y_r;
        ev_nxt[`MPO_ST_PASS] = pass_nxt;
    end

    always @* begin
        status_nxt = (status_r & ~clr_nxt) | ev_nxt;
    end

    // sticky status: a set wins over a same-cycle clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= `MPO_ZERO5;
            irq <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq <= |(status_nxt & enable_r);
        end
    end

    // fifo next value: a pass refill wins over a release in one cycle
    always @* begin
        release_nxt = slow_clock_32k && slot_r == 4'h0 &&
            fifo_cnt_r != 4'h0;
        fifo_nxt = fifo_r;
        fifo_cnt_nxt = fifo_cnt_r;
        if (pass_nxt) begin
            // four copies of the w,v sign pair, w in the upper bit
            fifo_nxt = {4{pulse_r[0], pulse_r[1]}};
            fifo_cnt_nxt = `MPO_FIFO_FULL;
        end else if (release_nxt) begin
            // oldest pair leaves from the top
            fifo_nxt = {fifo_r[5:0], 2'b00};
            fifo_cnt_nxt = fifo_cnt_r - `MPO_PAIR;
        end
    end

    // aux pulses latched once per pass; fifo loaded per pass
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            x_r <= 1'b0;
            y_r <= 1'b0;
            fifo_r <= `MPO_ZERO8;
            fifo_cnt_r <= 4'h0;
        end else begin
            fifo_r <= fifo_nxt;
            fifo_cnt_r <= fifo_cnt_nxt;
            if (pass_nxt) begin
                x_r <= pulse_r[2] & ctrl_r[`MPO_C_EXPORT_X];
                y_r <= pulse_r[3] & ctrl_r[`MPO_C_EXPORT_Y];
            end
        end
    end

    // frame of 13 slow ticks, release one pair at frame slot 0 spread
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_r <= 4'h0;
            w_r <= 1'b0;
            v_r <= 1'b0;
        end else if (slow_clock_32k) begin
            slot_r <= (slot_r == SPREAD - 1) ? 4'h0 : slot_r + 4'd1;
            if (release_nxt) begin
                w_r <= fifo_r[7];
                v_r <= fifo_r[6];
            end
        end
    end

    // one invert bit sets the polarity of all four outputs
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pol
            assign pin_nxt[g] = act[g] ^ ~inv;
        end
    endgenerate

    // equation 2 adds vb to the ia va ib sequence
    always @* begin
        case (meter_equation_select)
            3'd0: begin
                seq_len_nxt = `MPO_SEQ3;
            end
            3'd1: begin
                seq_len_nxt = `MPO_SEQ3;
            end
            `MPO_EQU_TWO: begin
                seq_len_nxt = `MPO_SEQ4;
            end
            default: begin
                seq_len_nxt = `MPO_SEQ3;
            end
        endcase
    end

    // output pins; reset shows the idle level of active-low pulses
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            real_energy_pulse <= 1'b1;
            reactive_energy_pulse <= 1'b1;
            segment_io_six <= 1'b1;
            segment_io_seven <= 1'b1;
            mux_sequence_len <= `MPO_SEQ3;
        end else begin
            real_energy_pulse <= pin_nxt[0];
            reactive_energy_pulse <= pin_nxt[1];
            segment_io_six <= pin_nxt[2];
            segment_io_seven <= pin_nxt[3];
            mux_sequence_len <= seq_len_nxt;
        end
    end

    // ram word address of the monitor slot after the current one
    always @* begin
        mon_next_addr_nxt = mon_addr_r[9:0];
        case (word_r)
            2'd0: begin
                mon_next_addr_nxt = mon_addr_r[19:10];
            end
            2'd1: begin
                mon_next_addr_nxt = mon_addr_r[29:20];
            end
            2'd2: begin
                mon_next_addr_nxt = {mon_addr_r[31:30], 8'h00};
            end
            default: begin
                mon_next_addr_nxt = mon_addr_r[9:0];
            end
        endcase
    end

    // real-time monitor serialiser, bits on test bit clock strobes;
    // a word takes a load cycle plus one strobe per bit, so the strobe
    // rate sets the word time; ram data is read in the load cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            word_r <= 2'd0;
            bit_r <= 6'd0;
            shreg_r <= 35'h0_0000_0000;
            ram_addr <= 10'h000;
            mon_data_r <= `MPO_ZERO32;
            test_mux_output_pin <= 1'b0;
        end else if (!mon_en) begin
            state_r <= ST_IDLE;
            test_mux_output_pin <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (pass_nxt) begin
                        word_r <= 2'd0;
                        ram_addr <= mon_addr_r[9:0];
                        state_r <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    mon_data_r <= ram_rdata;
                    shreg_r <= {3'b100, ram_rdata};
                    bit_r <= 6'd0;
                    state_r <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (test_bit_clock) begin
                        test_mux_output_pin <= shreg_r[34];
                        shreg_r <= {shreg_r[33:0], 1'b0};
                        if (word_last) begin
                            if (round_last) begin
                                state_r <= ST_IDLE;
                            end else begin
                                word_r <= word_r + 2'd1;
                                ram_addr <= mon_next_addr_nxt;
                                state_r <= ST_LOAD;
                            end
                        end else begin
                            bit_r <= bit_r + 6'd1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

// [test/mpo_monitor.sv]
/* port assertions of mpo_top.
   assumes: bound to mpo_top; one hclk domain; zero-wait bus. */
`timescale 1ns/1ps
`default_nettype none
`include "mpo_map.vh"
module mpo_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic test_bit_clock,
    input wire logic slow_clock_32k,
    input wire logic test_mux_output_pin,
    input wire logic real_energy_pulse,
    input wire logic segment_io_six,
    input wire logic segment_io_seven,
    input wire logic [2:0] mux_sequence_len
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic wa_r, wc_r;
    logic [3:0] sc_r, ss_r;
    wire logic tk = hsel && hready && htrans[1] && hwrite;
    // cycles since a control write, and since any write or slow tick
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wa_r <= 1'h0;
            wc_r <= 1'h0;
            sc_r <= 4'h0;
            ss_r <= 4'h0;
        end else begin
            wa_r <= tk;
            wc_r <= tk && haddr[11:0] == `MPO_A_CTRL;
            sc_r <= wc_r ? 4'h0 : sc_r + {3'h0, sc_r != 4'hf};
            ss_r <= wa_r || slow_clock_32k ? 4'h0 : ss_r + {3'h0, ss_r != 4'hf};
        end
    end
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    AST_EQU_WIDE: assert property (wc_r && hwdata[6:4] == 3'h2 |->
        ##2 mux_sequence_len == 3'h4) else $error("len not four");
    AST_EQU_NARROW: assert property (wc_r && hwdata[6:4] != 3'h2 |->
        ##2 mux_sequence_len == 3'h3) else $error("len not three");
    AST_MON_OFF: assert property (wc_r && !hwdata[0] |->
        ##[1:2] !test_mux_output_pin) else $error("monitor not stopped");
    AST_MON_BITCLK: assert property ($rose(test_mux_output_pin) |->
        $past(test_bit_clock) || $past(test_bit_clock, 2))
        else $error("monitor bit without strobe");
    AST_AUX_X: assert property ($changed(segment_io_six) |->
        sc_r <= 4'h3) else $error("x changed outside pass");
    AST_AUX_Y: assert property ($changed(segment_io_seven) |->
        sc_r <= 4'h3) else $error("y changed outside pass");
    AST_ENERGY_SLOT: assert property ($changed(real_energy_pulse) |->
        ss_r <= 4'h3) else $error("energy pulse off slot");
endmodule
`default_nettype wire

// [test/mpo_ram_model.sv]
/* shared data ram stand-in: data follows ram_addr in the same cycle,
   so the design's load cycle after the address sees it.
   assumes: one word per address. */
`timescale 1ns/1ps
`default_nettype none
module mpo_ram_model (
    input wire logic hclk,
    input wire logic [9:0] ram_addr,
    output logic [31:0] ram_rdata
);
    // each word encodes its own address so a misrouted read shows
    always_comb begin
        ram_rdata = {2'h2, ram_addr, ~ram_addr, ram_addr};
    end
endmodule
`default_nettype wire

// [test/mpo_top_tb_top.sv]
/* self-checking bench of mpo_top with random pulse sources.
   assumes: mpo_map.vh on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "mpo_map.vh"
module mpo_top_tb_top;
    logic hclk, hresetn, hwrite, tbc, sck, tmux, pw, pv, s6, s7, irq;
    logic hrdy, hresp;
    logic [1:0] htrans;
    logic [2:0] mlen;
    logic [9:0] ram_addr, a;
    logic [31:0] haddr, hwdata, hrdata, rd, ram_rdata, v;
    logic [34:0] sh;
    integer err_total, checked, seed, i;
    mpo_top i_mpo_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
        .engine_clock(1'h0), .test_bit_clock(tbc), .slow_clock_32k(sck),
        .test_mux_output_pin(tmux), .real_energy_pulse(pw),
        .reactive_energy_pulse(pv), .segment_io_six(s6),
        .segment_io_seven(s7), .mux_sequence_len(mlen), .irq(irq));
    mpo_ram_model i_mpo_ram_model (.hclk(hclk), .ram_addr(ram_addr),
        .ram_rdata(ram_rdata));
    initial begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end
    function automatic logic [1:0] pol(input logic [1:0] act, input logic inv);
        return act ^ {2{~inv}};
    endfunction
    task chk(input string nm, input logic [31:0] seen, exp);
        checked = checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task bus(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {20'h0_0000, ad};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hrdy !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hrdy !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask
    task strobe;
        @(posedge hclk);
        tbc <= 1'h1;
        @(posedge hclk);
        tbc <= 1'h0;
        @(posedge hclk);
        sh = {sh[33:0], tmux};
    endtask
    task final_report;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #2_000_000;
        err_total = err_total + 1;
        final_report;
    end
    initial begin
        seed = 32'h0000_fc66;
        err_total = 0;
        checked = 0;
        {hresetn, hwrite, tbc, sck, htrans, haddr, hwdata, sh} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        chk("rst", 32'({pw, pv, s6, s7, irq, mlen, tmux}), 32'h0000_01e6);
        bus(1'h0, 12'h040, 32'h0);
        chk("map", rd, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            bus(1'h1, `MPO_A_CTRL, 32'(i * 16));
            repeat (2) @(posedge hclk);
            chk("len", 32'(mlen), i == 2 ? 32'h4 : 32'h3);
        end
        for (i = 0; i < 4; i = i + 1) begin
            v = $random(seed);
            bus(1'h1, `MPO_A_PULSE, v);
            bus(1'h1, `MPO_A_CTRL, 32'h0000_0304 + 32'(i % 2 * 2));
            repeat (3) @(posedge hclk);
            chk("aux", 32'({s6, s7}), 32'(pol({v[2], v[3]}, i[0])));
            bus(1'h1, `MPO_A_PULSE, ~v);
            repeat (3) @(posedge hclk);
            chk("hold", 32'({s6, s7}), 32'(pol({v[2], v[3]}, i[0])));
        end
        bus(1'h1, `MPO_A_CLEAR, 32'h0000_001f);
        bus(1'h1, `MPO_A_ENABLE, 32'h0000_0010);
        bus(1'h1, `MPO_A_CTRL, 32'h4);
        repeat (3) @(posedge hclk);
        chk("irq", 32'(irq), 32'h1);
        bus(1'h0, `MPO_A_STATUS, 32'h0);
        chk("sts", rd & 32'h0000_0010, 32'h0000_0010);
        bus(1'h1, `MPO_A_CLEAR, 32'h0000_0010);
        repeat (2) @(posedge hclk);
        chk("clr", 32'(irq), 32'h0);
        bus(1'h1, `MPO_A_ENABLE, 32'h0);
        bus(1'h1, `MPO_A_CTRL, 32'h4);
        repeat (3) @(posedge hclk);
        chk("mask", 32'(irq), 32'h0);
        bus(1'h1, `MPO_A_PULSE, 32'h1);
        bus(1'h1, `MPO_A_CTRL, 32'h4);
        repeat (13) begin
            @(posedge hclk);
            sck <= 1'h1;
            @(posedge hclk);
            sck <= 1'h0;
        end
        repeat (3) @(posedge hclk);
        chk("energy", 32'({pw, pv}), 32'(pol(2'h2, 1'h0)));
        bus(1'h1, `MPO_A_CTRL, 32'h2);
        repeat (3) @(posedge hclk);
        chk("inv", 32'({pw, pv}), 32'(pol(2'h2, 1'h1)));
        a = 10'($random(seed));
        bus(1'h1, `MPO_A_MON_ADDR, {22'h00_0000, a});
        bus(1'h1, `MPO_A_CTRL, 32'h5);
        repeat (3) @(posedge hclk);
        repeat (35) strobe;
        chk("flag", 32'(sh[34:32]), 32'h4);
        chk("word", sh[31:0], {2'h2, a, ~a, a});
        bus(1'h1, `MPO_A_CTRL, 32'h5);
        repeat (3) @(posedge hclk);
        strobe;
        chk("bit", 32'(tmux), 32'h1);
        bus(1'h1, `MPO_A_CTRL, 32'h0);
        repeat (2) @(posedge hclk);
        chk("stop", 32'(tmux), 32'h0);
        final_report;
    end
endmodule
bind mpo_top mpo_monitor i_mpo_monitor (.*);
`default_nettype wire
